// file: design/dbf_host_ctrl.sv
`timescale 1ns/1ps
// How it works
// [R01] reads to other bank go while busy
// [R02] two banks: boot sectors, uniform code sectors
// [R03] commands are ordinary bus write cycles
// [R04] program runs itself after sequence ends
// [R05] short program uses two write cycles
// [R06] erase runs itself, preprogram then pulses
// [R07] completion seen on busy pin or polling
// [R08] device returns to array read by itself
// [R09] sector erase leaves other sectors intact
// [R10] protected sectors refuse program and erase
// [R11] suspended erase allows other-sector access
// [R12] other-bank reads need no erase suspend
// [R13] reset pin aborts and returns to reads
// [R14] device sleeps when addresses stay still
// [R15] chip select high puts device in standby
// [R16] word data on lines 0..15
// [R17] strobes only; data bus never contended
// [R18] erase by sector, program one word
// [R19] wait for completion before next operation
module dbf_host_ctrl #(
    parameter int POLL_LIMIT = 100000                  // polls before timeout
) (
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    input  wire logic                       req_valid,
    input  wire dbf_pkg::dbf_req_t          req,
    output logic                            req_ready,
    output logic                            rsp_valid,
    output logic [dbf_pkg::DATA_W-1:0]      rsp_data,
    output logic                            rsp_timeout,
    output logic                            bank_busy,
    input  wire logic                       hw_reset_req,
    output dbf_pkg::dbf_pins_t              pins,
    output logic [dbf_pkg::DATA_W-1:0]      data_lines_o,
    output logic                            data_lines_oe_n,
    input  wire logic [dbf_pkg::DATA_W-1:0] data_lines_i,
    input  wire logic                       op_pending_out
);
    import dbf_pkg::*;

    // elaboration check: a poll loop needs at least one read
    if (POLL_LIMIT < 1) begin : g_bad_limit
        $error("POLL_LIMIT must be positive");
    end

    // one-hot sequencer states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,                              // chip deselected, standby
        ST_SETUP = 7'h02,                              // chip selected, strobes high; address loads on exit
        ST_WSTB  = 7'h04,                              // write strobe low
        ST_WREC  = 7'h08,                              // strobe high, recovery
        ST_RSTB  = 7'h10,                              // output drive low, wait access
        ST_RCAP  = 7'h20,                              // sample data
        ST_RST   = 7'h40                               // reset pin held low
    } dbf_st_t;

    dbf_st_t             st_r, st_nxt;
    dbf_req_t            cur_r;                        // active request
    logic [1:0]          step_r;                       // write cycle index in sequence
    logic [CNT_W-1:0]    cnt_r;                        // strobe/access timer
    logic [31:0]         polls_r;                      // poll attempts
    logic [DATA_W-1:0]   last_r;                       // previous poll sample
    logic                have_last_r;
    logic [1:0]          rdy_sync_r;                   // busy pin synchroniser
    logic [DATA_W-1:0]   d_s1_r, d_s2_r;               // data bus synchroniser
    dbf_pins_t           pins_r;
    logic [DATA_W-1:0]   dout_r;
    logic                doe_n_r;
    logic                req_ready_r, rsp_valid_r, rsp_to_r, busy_r;
    logic [DATA_W-1:0]   rsp_data_r;

    // two-stage capture of pin inputs; only stage two is read
    always_ff @(posedge ref_clk) begin
        rdy_sync_r <= {rdy_sync_r[0], op_pending_out};
        d_s1_r     <= data_lines_i;
        d_s2_r     <= d_s1_r;
    end

    wire pending_pin = ~rdy_sync_r[1];                 // busy pin is low while running
    wire timer_done  = (cnt_r == '0);
    // index of the last write cycle in each order
    wire [1:0] last_step = (cur_r.op == DBF_OP_PROG)  ? 2'h3 :
                           (cur_r.op == DBF_OP_SHORT) ? 2'h1 : 2'h0;
    wire is_write_op = (cur_r.op == DBF_OP_WRITE) || (cur_r.op == DBF_OP_PROG) ||
                       (cur_r.op == DBF_OP_SHORT);
    // address/data of the current write step
    wire [ADDR_W-1:0] wr_addr = (cur_r.op == DBF_OP_PROG && step_r == 2'h0) ? UNLOCK_A1 :
                                (cur_r.op == DBF_OP_PROG && step_r == 2'h1) ? UNLOCK_A2 :
                                (cur_r.op == DBF_OP_PROG && step_r == 2'h2) ? UNLOCK_A1 :
                                (cur_r.op == DBF_OP_SHORT && step_r == 2'h0) ? UNLOCK_A1 : // R05
                                cur_r.addr;
    wire [DATA_W-1:0] wr_data = (cur_r.op == DBF_OP_PROG && step_r == 2'h0) ? UNLOCK_D1 :
                                (cur_r.op == DBF_OP_PROG && step_r == 2'h1) ? UNLOCK_D2 :
                                (cur_r.op == DBF_OP_PROG && step_r == 2'h2) ? PROG_CMD :
                                (cur_r.op == DBF_OP_SHORT && step_r == 2'h0) ? PROG_CMD :
                                cur_r.data;
    // done needs both: toggle bit stopped and busy pin released
    wire toggled   = have_last_r && (last_r[TOGGLE_BIT] != d_s2_r[TOGGLE_BIT]);
    wire poll_done = have_last_r && !toggled && !pending_pin; // R07
    wire poll_to   = (polls_r >= 32'(POLL_LIMIT));

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:  if (hw_reset_req) st_nxt = ST_RST;
                      else if (req_valid) st_nxt = ST_SETUP; // R12 reads go whatever the busy pin says
            ST_SETUP: st_nxt = is_write_op ? ST_WSTB : ST_RSTB;
            ST_WSTB:  if (timer_done) st_nxt = ST_WREC;
            ST_WREC:  if (timer_done) st_nxt = (step_r == last_step) ? ST_IDLE : ST_SETUP;
            ST_RSTB:  if (timer_done) st_nxt = ST_RCAP;
            ST_RCAP:  if (cur_r.op != DBF_OP_POLL || poll_done || poll_to) st_nxt = ST_IDLE;
                      else st_nxt = ST_SETUP;                // R07 each poll is its own read cycle
            ST_RST:   if (timer_done) st_nxt = ST_IDLE;
            default:  st_nxt = ST_IDLE;
        endcase
    end

    // state and timers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            step_r <= 2'h0;
            cur_r <= '0;
        end else begin
            st_r <= st_nxt;
            if (st_r == ST_IDLE && req_valid && !hw_reset_req) begin
                cur_r  <= req;
                step_r <= 2'h0;
            end
            if (st_r == ST_WREC && timer_done) step_r <= step_r + 2'h1;
            if (st_nxt != st_r || st_r == ST_RCAP)
                cnt_r <= (st_nxt == ST_RSTB) ? CNT_W'(T_ACC_CYC) : CNT_W'(T_WP_CYC);
            else if (!timer_done)
                cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    // poll bookkeeping
    always_ff @(posedge ref_clk) begin
        if (srst || st_r == ST_IDLE) begin
            polls_r <= '0;
            have_last_r <= 1'b0;
            last_r <= '0;
        end else if (st_r == ST_RCAP) begin
            polls_r <= polls_r + 32'h1;
            have_last_r <= 1'b1;
            last_r <= d_s2_r;
        end
    end

    // pin drive; data only while output drive is off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pins_r <= '{chip_sel_n: 1'b1, wr_strobe_n: 1'b1, out_drv_n: 1'b1, reset_n: 1'b0, addr: '0};
            dout_r <= '0;
            doe_n_r <= 1'b1;
        end else begin
            pins_r.chip_sel_n  <= (st_nxt == ST_IDLE) || (st_nxt == ST_RST); // R15
            pins_r.wr_strobe_n <= (st_nxt != ST_WSTB);                       // R03
            pins_r.out_drv_n   <= !(st_nxt == ST_RSTB || st_nxt == ST_RCAP); // R17
            pins_r.reset_n     <= (st_nxt != ST_RST);                        // R13
            // leaving setup: order and step index are current only from here on
            if (st_r == ST_SETUP)
                pins_r.addr <= is_write_op ? wr_addr : cur_r.addr;
            dout_r  <= wr_data;
            doe_n_r <= !(st_nxt == ST_WSTB || st_nxt == ST_WREC);           // R17
        end
    end

    // user answers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_to_r <= 1'b0;
            rsp_data_r <= '0;
            busy_r <= 1'b0;
        end else begin
            req_ready_r <= (st_nxt == ST_IDLE) && !hw_reset_req;
            rsp_valid_r <= (st_r == ST_RCAP && st_nxt == ST_IDLE) ||
                           (st_r == ST_WREC && st_nxt == ST_IDLE);
            rsp_to_r    <= (st_r == ST_RCAP) && poll_to && !poll_done;
            if (st_r == ST_RCAP) rsp_data_r <= d_s2_r;
            busy_r      <= pending_pin;                                      // R19
        end
    end

    assign pins            = pins_r;
    assign data_lines_o    = dout_r;
    assign data_lines_oe_n = doe_n_r;
    assign req_ready       = req_ready_r;
    assign rsp_valid       = rsp_valid_r;
    assign rsp_timeout     = rsp_to_r;
    assign rsp_data        = rsp_data_r;
    assign bank_busy       = busy_r;

    AST_STROBE_EXCL: assert property (@(posedge ref_clk) disable iff (srst) // R17
        !(pins_r.wr_strobe_n == 1'b0 && pins_r.out_drv_n == 1'b0))
        else $error("write strobe and output drive both low");
    AST_NO_CONTEND: assert property (@(posedge ref_clk) disable iff (srst) // R17
        !(doe_n_r == 1'b0 && pins_r.out_drv_n == 1'b0))
        else $error("data bus contended");
    AST_WSTB_CS: assert property (@(posedge ref_clk) disable iff (srst) // R03
        !pins_r.wr_strobe_n |-> !pins_r.chip_sel_n)
        else $error("write strobe without chip select");
    AST_RST_PIN: assert property (@(posedge ref_clk) disable iff (srst) // R13
        (st_r == ST_IDLE && hw_reset_req) |=> !pins_r.reset_n)
        else $error("reset pin not driven");
    AST_STANDBY: assert property (@(posedge ref_clk) disable iff (srst) // R15
        (st_r == ST_IDLE) |-> pins_r.chip_sel_n)
        else $error("chip selected while idle");
    AST_SHORT_PROG: assert property (@(posedge ref_clk) disable iff (srst) // R05
        (st_r == ST_WREC && cur_r.op == DBF_OP_SHORT && step_r == 2'h1 && timer_done) |=> st_r == ST_IDLE)
        else $error("short program not two cycles");
    AST_POLL_END: assert property (@(posedge ref_clk) disable iff (srst) // R07
        (st_r == ST_RCAP && cur_r.op == DBF_OP_POLL && poll_done) |=> rsp_valid_r)
        else $error("poll completion missed");
    AST_BUSY_MIRROR: assert property (@(posedge ref_clk) disable iff (srst) // R19
        $fell(rdy_sync_r[1]) |=> busy_r)
        else $error("busy not reported");
endmodule

// file: design/dbf_pkg.sv
package dbf_pkg;
    // bus geometry (word mode)
    localparam int ADDR_W      = 18;                     // 262,144 words
    localparam int DATA_W      = 16;                     // data lines 0..15
    localparam int BYTE_W      = 8;                      // byte mode lanes 0..7
    // bus cycle timing, ns and derived cycles at 250 MHz
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_ACC_NS      = 70;                   // least access time
    localparam int T_WP_NS       = 35;                   // least write strobe width
    localparam int T_ACC_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_WP_CYC      = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 8;
    // status bit positions in a read word
    localparam int POLL_BIT      = 7;                    // poll_status_bit
    localparam int TOGGLE_BIT    = 6;                    // toggle_status_bit
    // command words written as plain data; values are fixed in this package
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 18'h00555; // first unlock address
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 18'h002aa; // second unlock address
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] PROG_CMD  = 16'h00a0; // program setup word
    // array map: small boot sectors low, uniform code sectors from here up
    localparam logic [ADDR_W-1:0] BANK2_BASE = 18'h10000;
    // top code sector, locked in the far-side model for the refusal test
    localparam logic [ADDR_W-1:0] PROT_BASE  = 18'h38000;

    // user order codes
    typedef enum logic [2:0] {
        DBF_OP_READ   = 3'h0,                            // single array read
        DBF_OP_WRITE  = 3'h1,                            // raw command write cycle
        DBF_OP_PROG   = 3'h2,                            // full four-cycle program
        DBF_OP_SHORT  = 3'h3,                            // two-cycle short program
        DBF_OP_POLL   = 3'h4                             // poll until done
    } dbf_op_t;

    // one user request
    typedef struct packed {
        dbf_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } dbf_req_t;

    // pins driven at the device
    typedef struct packed {
        logic                chip_sel_n;
        logic                wr_strobe_n;
        logic                out_drv_n;
        logic                reset_n;
        logic [ADDR_W-1:0]   addr;
    } dbf_pins_t;
endpackage

// file: tb/dbf_flash_model.sv
`timescale 1ns/1ps
// behavioural flash device facing the controller; ref_clk only keeps time
module dbf_flash_model (
    input  wire logic                       ref_clk,
    input  wire logic                       slow,
    input  wire dbf_pkg::dbf_pins_t         pins,
    input  wire logic [dbf_pkg::DATA_W-1:0] host_d,
    input  wire logic                       host_oe_n,
    output logic [dbf_pkg::DATA_W-1:0]      wire_d,
    output logic                            busy_n
);
    import dbf_pkg::*;
    logic [DATA_W-1:0] mem [int];   // sparse array, unwritten reads erased
    logic [DATA_W-1:0] pdata;       // latched program data
    logic [DATA_W-1:0] last_d;      // last level seen on the data wires
    logic [ADDR_W-1:0] paddr;       // latched program address
    int                left = 0;    // cycles left in the embedded routine
    int                step = 0;    // unlock sequence position
    logic              tog = 1'b0;  // toggle bit state
    // array word or status; status only for the bank that is busy
    function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
        if (left != 0 && ((a >= BANK2_BASE) == (paddr >= BANK2_BASE)))
            return {pdata[15:8], ~pdata[7], tog, pdata[5:0]};
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // released wires show the inverse of the last level, never a stale copy
    always_comb begin
        if (!host_oe_n)
            wire_d = host_d;
        else if (!pins.chip_sel_n && !pins.out_drv_n && pins.reset_n)
            wire_d = rd(pins.addr);
        else
            wire_d = ~last_d;
    end
    assign busy_n = (left == 0);
    // every output-drive fall is a read: toggle while busy
    always @(negedge pins.out_drv_n) begin
        if (left != 0 && !pins.chip_sel_n)
            tog <= ~tog;
    end
    // commands are plain write cycles latched on the strobe's rise
    always @(posedge pins.wr_strobe_n) begin
        if (pins.chip_sel_n === 1'b0 && pins.reset_n === 1'b1 && left == 0) begin
            if (step == 3) begin
                paddr = pins.addr;
                pdata = host_d;
                step = 0;
                // a locked sector ignores the program and stays ready
                left = (pins.addr >= PROT_BASE) ? 0 : (slow ? 3000 : 300);
            end else if (pins.addr == UNLOCK_A1 && host_d == PROG_CMD)
                step = 3;
            else if (pins.addr == UNLOCK_A1 && host_d == UNLOCK_D1)
                step = 1;
            else if (step == 1 && pins.addr == UNLOCK_A2 && host_d == UNLOCK_D2)
                step = 2;
            else
                step = 0;
        end
    end
    // routine timer; bits only clear, one word per program
    always @(posedge ref_clk) begin
        last_d <= wire_d;
        if (pins.reset_n === 1'b0) begin
            left = 0;
            step = 0;
        end else if (left == 1) begin
            mem[paddr] = (mem.exists(paddr) ? mem[paddr] : 16'hffff);
            mem[paddr] = mem[paddr] & pdata;
            left = 0;
        end else if (left > 1)
            left = left - 1;
    end
endmodule

// file: tb/test_dual_bank_flash_command_control.sv
`timescale 1ns/1ps
// orders into the controller, results checked against a queue-free word model
module test_dual_bank_flash_command_control;
    import dbf_pkg::*;
    logic              ref_clk, srst, req_valid, hw_reset_req, slow;
    logic              req_ready, rsp_valid, rsp_timeout, bank_busy, oe_n, pend;
    logic [DATA_W-1:0] rsp_data, d_o, d_i, d;
    logic [ADDR_W-1:0] a;
    logic [31:0]       rnd;
    dbf_req_t          req;
    dbf_pins_t         pins;
    int                err_count, num_checks, cyc;
    int                exp_mem [int];    // expected array contents
    dbf_host_ctrl #(.POLL_LIMIT(64)) dut (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_timeout(rsp_timeout), .bank_busy(bank_busy), .hw_reset_req(hw_reset_req),
        .pins(pins), .data_lines_o(d_o), .data_lines_oe_n(oe_n), .data_lines_i(d_i),
        .op_pending_out(pend));
    dbf_flash_model u_flash (.ref_clk(ref_clk), .slow(slow), .pins(pins), .host_d(d_o),
        .host_oe_n(oe_n), .wire_d(d_i), .busy_n(pend));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] x);
        return exp_mem.exists(int'(x)) ? exp_mem[int'(x)][15:0] : 16'hffff;
    endfunction
    // an address of the same offset in the bank that x is not in
    function automatic logic [ADDR_W-1:0] other_bank(input logic [ADDR_W-1:0] x);
        return (x < BANK2_BASE) ? x + 18'h20000 : {2'b00, x[15:0]};
    endfunction
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // one order: offer when ready, hold one edge, wait for the answer pulse
    task automatic order(input dbf_op_t op, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
        while (req_ready !== 1'b1) @(negedge ref_clk);
        req_valid = 1'b1;
        req = {op, ad, dt};
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge ref_clk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {srst, req_valid, hw_reset_req, slow} = 4'h8;
        req = '0;
        {err_count, num_checks, cyc} = '0;
        rnd = 32'h0a676bfb;
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        check({15'h0, pins.chip_sel_n & oe_n}, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            a = rnd[ADDR_W-1:0];
            d = rnd[31:16];
            order(DBF_OP_READ, a, 16'h0); check(rsp_data, exp_rd(a));
            order(i[0] ? DBF_OP_SHORT : DBF_OP_PROG, a, d);
            if (a < PROT_BASE) exp_mem[int'(a)] = int'(exp_rd(a) & d);
            order(DBF_OP_READ, other_bank(a), 16'h0); check(rsp_data, exp_rd(other_bank(a)));
            check({15'h0, bank_busy}, {15'h0, a < PROT_BASE});
            order(DBF_OP_POLL, a, 16'h0); check({15'h0, rsp_timeout}, 16'h0000);
            order(DBF_OP_READ, a, 16'h0); check(rsp_data, exp_rd(a));
        end
        // locked sector: program refused, word stays erased, no busy
        order(DBF_OP_PROG, PROT_BASE, 16'h0000); check({15'h0, bank_busy}, 16'h0000);
        order(DBF_OP_READ, PROT_BASE, 16'h0); check(rsp_data, 16'hffff);
        // slow routine: poll gives up, then a reset pin pulse aborts it
        a[ADDR_W-1] = 1'b0;   // keep the slow program out of the locked sector
        slow = 1'b1;
        order(DBF_OP_PROG, a, 16'h0);
        order(DBF_OP_POLL, a, 16'h0); check({15'h0, rsp_timeout}, 16'h0001);
        hw_reset_req = 1'b1;
        @(negedge ref_clk);
        hw_reset_req = 1'b0;
        repeat (30) @(negedge ref_clk);
        check({15'h0, bank_busy}, 16'h0000);
        order(DBF_OP_READ, a, 16'h0); check(rsp_data, exp_rd(a));
        close_out();
    end
endmodule
